// File: rtl/aciu_regs.vh
/*
 * constants for the accumulator cpu instruction unit: word layout,
 * operation codes, no-address variants, status bit positions, register
 * port offsets and execution timing.
 * assumes a 250 mhz clock and a 24-bit word memory on the same clock.
 */
`ifndef ACIU_REGS_VH
`define ACIU_REGS_VH

// instruction word fields
`define F_OP        23:18
`define F_V         17:15
`define F_X         14:0
`define F_C         14:12
`define V_INDIRECT  3'h7

// operation codes
`define OP_ADD      6'h01
`define OP_ADDMEM   6'h02
`define OP_AUGIMM   6'h03
`define OP_BAR      6'h04
`define OP_DECJMP   6'h05
`define OP_REMOTE   6'h06
`define OP_JNEG     6'h07
`define OP_JPOS     6'h08
`define OP_JZERO    6'h09
`define OP_RESTORE  6'h0a
`define OP_NOADDR   6'h00

// no-address variants
`define NV_PASS     3'h0
`define NV_SHIFT    3'h1
`define NV_XFER     3'h2
`define NV_ISKIP    3'h3
`define NV_CSKIP    3'h4
`define NV_SETEXT   3'h5
`define NV_ESKIP    3'h6
`define NV_HALT     3'h7

// status bit positions in restore operand and skip field
`define SB_OVF      6
`define SB_CARRY    7
`define SB_EOVF     8
`define SB_EUNF     9
`define SB_DIVO     10
`define SB_BLOCK    11
`define SB_EMERG    12

// register port offsets
`define RA_CTRL     4'h0
`define RA_SEQ      4'h1
`define RA_ACC      4'h2
`define RA_FLAGS    4'h3
`define RA_SWITCH   4'h4
`define CTRL_CONT   0

// reset and interrupt locations
`define RESET_SEQ   15'h0000
`define INT_SAVE    15'h0020

// timing
`define CLK_PERIOD_PS 4000
`define ONE_US_PS     1000000
`define CYC_PER_US    (`ONE_US_PS / `CLK_PERIOD_PS)
`define T_INDEX_US    6'h01
`define T_INT_US      6'h02

`endif

// File: rtl/aciu_core.v
/*
 * accumulator cpu instruction unit: fetch, address resolution, execute
 * and timed completion of the instruction groups handled here.
 * assumes a word memory with read data valid in the mem_rd_ff cycle, io and
 * test-point pins from outside the clock domain, and io_wc_addr from
 * logic on the same clock.
 */
// What this block does
// - add sets accumulator, overflow or carry
// - add-to-memory writes sum, flags untouched
// - immediate augment adds field to index
// - branch-return stores next address, jumps X+1
// - decrement index, jump when nonzero
// - execute one word at X, then resume
// - jumps on accumulator sign or zero, flags ignored
// - restore status from operand bits 6-11
// - restored block loads at next fetch, gates interrupts from the fetch after
// - no-address orders share one code
// - shift single or double, left/right, rotate/arith
// - arith right copies sign, left fills zero
// - transfer modifier: straight, negative, absolute
// - transfer control: oneway, exchange, word-count source
// - internal skip when selected points all unset
// - internal skip clears tested sticky points except exponent overflow
// - control skip addresses device, skip without ack
// - control field carries questions and commands
// - set external points from operand bits
// - external skip when selected points all unset
// - halt with zero C field stops only instruction execution
// - indexing, indirection each add one microsecond
// - carry always last result, overflow test-cleared
`include "aciu_regs.vh"
`default_nettype none

module aciu_core (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	input  wire        ce,
	// word memory
	output reg  [14:0] mem_addr_ff,
	output reg         mem_rd_ff,
	output reg         mem_wr_ff,
	output reg  [23:0] mem_wdata_ff,
	input  wire [23:0] mem_rdata,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [23:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [23:0] reg_rdata_ff,
	// basic io bus
	output reg  [8:0]  io_dev_addr_ff,
	output reg  [5:0]  io_ctrl_ff,
	output reg         io_req_ff,
	input  wire        io_ack,
	input  wire [14:0] io_wc_addr,
	// test points and interrupts
	output reg  [14:0] ext_point_ff,
	input  wire [14:0] ext_point_in,
	input  wire        irq_in,
	input  wire        emerg_in,
	output reg         halted_ff
);
	localparam [7:0] S_FETCH = 8'h01;
	localparam [7:0] S_DEC   = 8'h02;
	localparam [7:0] S_INDIR = 8'h04;
	localparam [7:0] S_OPER  = 8'h08;
	localparam [7:0] S_EXEC  = 8'h10;
	localparam [7:0] S_SHIFT = 8'h20;
	localparam [7:0] S_WAIT  = 8'h40;
	localparam [7:0] S_HALT  = 8'h80;

	reg  [7:0]  state_ff;
	reg  [23:0] ir_ff;
	reg  [23:0] opnd_ff;
	reg  [23:0] acc_ff;
	reg  [23:0] breg_ff;
	reg  [14:0] seq_ff;
	reg  [14:0] ea_ff;
	reg  [5:0]  budget_ff;
	reg  [15:0] elapsed_ff;
	reg  [5:0]  shcnt_ff;
	reg         remote_ff;
	reg         ovf_ff, carry_ff, eovf_ff, eunf_ff, divo_ff;
	reg         blk_ff, blk_pend_ff, emerg_ff, ack_seen_ff;
	reg  [5:0]  switch_ff;
	reg  [17:0] sync1_ff, sync2_ff;
	reg  [14:0] xr_ff [0:7];

	// pins pass two flops before use
	wire [14:0] ext_s = sync2_ff[14:0];
	wire        ack_s = sync2_ff[15];
	wire        irq_s = sync2_ff[16];
	wire        emg_s = sync2_ff[17];

	wire [5:0]  op   = ir_ff[`F_OP];
	wire [2:0]  iv   = ir_ff[`F_V];
	wire [14:0] ix   = ir_ff[`F_X];
	wire [2:0]  ic   = ir_ff[`F_C];
	wire [14:0] xsel = xr_ff[iv];

	// address resolution works straight off the memory word
	wire [5:0]  r_op  = (state_ff == S_DEC) ? mem_rdata[`F_OP] : op;
	wire [2:0]  r_v   = mem_rdata[`F_V];
	wire [14:0] r_x   = mem_rdata[`F_X];
	wire        r_nad = (r_op == `OP_NOADDR);
	wire        r_fix = (r_op == `OP_AUGIMM) || (r_op == `OP_DECJMP);
	wire        r_ind = !r_nad && !r_fix && (r_v == `V_INDIRECT);
	wire        r_idx = !r_nad && !r_fix && (r_v != 3'h0) && !r_ind;
	wire [14:0] r_ea  = r_idx ? r_x + xr_ff[r_v] : r_x;
	wire        r_mem = (r_op == `OP_ADD) || (r_op == `OP_ADDMEM)
		|| (r_op == `OP_RESTORE);

	wire [24:0] sum   = {1'b0, acc_ff} + {1'b0, opnd_ff};
	wire        sovf  = (acc_ff[23] == opnd_ff[23]) && (sum[23] != acc_ff[23]);
	wire [31:0] target_w = {26'h0, budget_ff} * `CYC_PER_US;
	wire [15:0] target   = target_w[15:0];

	// internal test points: switches, flags, block, emergency
	wire [14:0] tpoint = {2'h0, emerg_ff, blk_ff, divo_ff, eunf_ff, eovf_ff,
		carry_ff, ovf_ff, switch_ff};
	wire [14:0] tsel   = tpoint & ix;

	// register transfer operands
	wire [2:0]  t_c   = ix[14:12];
	wire [1:0]  t_mod = ix[11:10];
	wire [2:0]  t_src = ix[5:3];
	wire [2:0]  t_dst = ix[2:0];
	wire        t_ok  = (state_ff == S_EXEC) && (op == `OP_NOADDR) && (iv == `NV_XFER)
		&& !t_c[2];

	function [23:0] rsel;
		input [2:0] code;
		begin
			case (code)
				3'h0:    rsel = acc_ff;
				3'h1:    rsel = breg_ff;
				default: rsel = {9'h0, xr_ff[code - 3'h1]};
			endcase
		end
	endfunction

	function [5:0] base_us;
		input [5:0] o;
		input [2:0] v;
		begin
			case (o)
				`OP_ADDMEM: base_us = 6'h07;
				`OP_AUGIMM: base_us = 6'h03;
				`OP_BAR:    base_us = 6'h06;
				`OP_REMOTE: base_us = 6'h01;
				`OP_NOADDR: base_us = (v == `NV_ISKIP || v == `NV_ESKIP) ? 6'h03 :
					(v == `NV_CSKIP) ? 6'h04 : 6'h02;
				default: base_us = 6'h02;
			endcase
		end
	endfunction

	reg  [23:0] t_raw, t_val;
	always @*
	begin
		t_raw = t_c[1] ? {9'h0, io_wc_addr} : rsel(t_src);
		case (t_mod)
			2'h1:    t_val = -t_raw;
			2'h2:    t_val = t_raw[23] ? -t_raw : t_raw;
			default: t_val = t_raw;
		endcase
		if (t_c[0])
			t_val = t_raw;
	end

	// index register write port
	reg         xr_we;
	reg  [2:0]  xr_idx;
	reg  [14:0] xr_val;
	reg  [23:0] xr_alt;
	always @*
	begin
		xr_alt = rsel(t_dst);
		xr_we  = 1'b0;
		xr_idx = iv;
		xr_val = 15'h0;
		if (state_ff == S_EXEC && op == `OP_AUGIMM)
		begin
			xr_we  = 1'b1;
			xr_val = xsel + ix;
		end
		else if (state_ff == S_EXEC && op == `OP_DECJMP)
		begin
			xr_we  = 1'b1;
			xr_val = xsel - 15'h1;
		end
		else if (t_ok && t_dst >= 3'h2)
		begin
			xr_we  = 1'b1;
			xr_idx = t_dst - 3'h1;
			xr_val = t_val[14:0];
		end
		else if (t_ok && t_c[0] && t_src >= 3'h2)
		begin
			xr_we  = 1'b1;
			xr_idx = t_src - 3'h1;
			xr_val = xr_alt[14:0];
		end
		if (xr_idx == 3'h0 || xr_idx == 3'h7)
			xr_we = 1'b0;
	end

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : g_xr
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					xr_ff[g] <= 15'h0;
				else if (ce && xr_we && xr_idx == g)
					xr_ff[g] <= xr_val;
			end
		end
	endgenerate

	// pin synchronisers
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_ff <= 18'h0;
			sync2_ff <= 18'h0;
		end
		else if (ce)
		begin
			sync1_ff <= {emerg_in, irq_in, io_ack, ext_point_in};
			sync2_ff <= sync1_ff;
		end
	end

	// register port; seq writes only land while halted
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata_ff <= 24'h0;
			switch_ff    <= 6'h0;
		end
		else if (ce)
		begin
			if (reg_wr && reg_addr == `RA_SWITCH)
				switch_ff <= reg_wdata[5:0];
			reg_rdata_ff <= 24'h0;
			if (reg_rd)
			begin
				case (reg_addr)
					`RA_SEQ:    reg_rdata_ff <= {9'h0, seq_ff};
					`RA_ACC:    reg_rdata_ff <= acc_ff;
					`RA_FLAGS:  reg_rdata_ff <= {10'h0, halted_ff, tpoint[12:6], 6'h0};
					`RA_SWITCH: reg_rdata_ff <= {18'h0, switch_ff};
					default:    reg_rdata_ff <= 24'h0;
				endcase
			end
		end
	end

	wire cont = reg_wr && reg_addr == `RA_CTRL && reg_wdata[`CTRL_CONT];

	// sequencer
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= S_FETCH;
			ir_ff <= 24'h0;
			opnd_ff <= 24'h0;
			acc_ff <= 24'h0;
			breg_ff <= 24'h0;
			seq_ff <= `RESET_SEQ;
			ea_ff <= 15'h0;
			budget_ff <= 6'h0;
			elapsed_ff <= 16'h0;
			shcnt_ff <= 6'h0;
			remote_ff <= 1'b0;
			{ovf_ff, carry_ff, eovf_ff, eunf_ff, divo_ff} <= 5'h0;
			{blk_ff, blk_pend_ff, emerg_ff, ack_seen_ff} <= 4'h0;
			mem_addr_ff <= 15'h0;
			mem_rd_ff <= 1'b0;
			mem_wr_ff <= 1'b0;
			mem_wdata_ff <= 24'h0;
			io_dev_addr_ff <= 9'h0;
			io_ctrl_ff <= 6'h0;
			io_req_ff <= 1'b0;
			ext_point_ff <= 15'h0;
			halted_ff <= 1'b0;
		end
		else if (ce)
		begin
			mem_rd_ff <= 1'b0;
			mem_wr_ff <= 1'b0;
			elapsed_ff <= elapsed_ff + 16'h1;
			if (io_req_ff && ack_s)
				ack_seen_ff <= 1'b1;
			case (state_ff)
				S_FETCH:
				begin
					if (remote_ff)
					begin
						remote_ff <= 1'b0;
						mem_rd_ff <= 1'b1;
						mem_addr_ff <= ea_ff;
						state_ff <= S_DEC;
					end
					else if (irq_s && !blk_ff)
					begin
						mem_wr_ff <= 1'b1;
						mem_addr_ff <= `INT_SAVE;
						mem_wdata_ff <= {9'h0, seq_ff};
						seq_ff <= `INT_SAVE + 15'h1;
						blk_ff <= 1'b1;
						blk_pend_ff <= 1'b1;
						budget_ff <= `T_INT_US;
						elapsed_ff <= 16'h0;
						state_ff <= S_WAIT;
					end
					else
					begin
						mem_rd_ff <= 1'b1;
						mem_addr_ff <= seq_ff;
						seq_ff <= seq_ff + 15'h1;
						blk_ff <= blk_pend_ff;
						budget_ff <= 6'h0;
						elapsed_ff <= 16'h0;
						state_ff <= S_DEC;
					end
				end
				S_DEC, S_INDIR:
				begin
					if (state_ff == S_DEC)
					begin
						ir_ff <= mem_rdata;
						budget_ff <= budget_ff + base_us(mem_rdata[`F_OP], r_v);
					end
					ea_ff <= r_ea;
					if (r_ind)
					begin
						mem_rd_ff <= 1'b1;
						mem_addr_ff <= r_x;
						state_ff <= S_INDIR;
					end
					else if (r_mem)
					begin
						mem_rd_ff <= 1'b1;
						mem_addr_ff <= r_ea;
						state_ff <= S_OPER;
					end
					else
						state_ff <= S_EXEC;
					if (r_ind || r_idx)
					begin
						if (state_ff == S_DEC)
							budget_ff <= budget_ff + base_us(mem_rdata[`F_OP], r_v)
								+ `T_INDEX_US;
						else
							budget_ff <= budget_ff + `T_INDEX_US;
					end
				end
				S_OPER:
				begin
					opnd_ff <= mem_rdata;
					state_ff <= S_EXEC;
				end
				S_EXEC:
				begin
					state_ff <= S_WAIT;
					case (op)
						`OP_ADD:
						begin
							acc_ff <= sum[23:0];
							carry_ff <= sum[24];
							if (sovf)
								ovf_ff <= 1'b1;
						end
						`OP_ADDMEM:
						begin
							mem_wr_ff <= 1'b1;
							mem_addr_ff <= ea_ff;
							mem_wdata_ff <= sum[23:0];
						end
						`OP_BAR:
						begin
							mem_wr_ff <= 1'b1;
							mem_addr_ff <= ea_ff;
							mem_wdata_ff <= {9'h0, seq_ff};
							seq_ff <= ea_ff + 15'h1;
						end
						`OP_DECJMP:
							if (xsel != 15'h1)
								seq_ff <= ix;
						`OP_REMOTE:
						begin
							remote_ff <= 1'b1;
							state_ff <= S_FETCH;
						end
						// sign and zero only; overflow and carry never consulted
						`OP_JNEG:
							if (acc_ff[23])
								seq_ff <= ea_ff;
						`OP_JPOS:
							if (!acc_ff[23] && acc_ff != 24'h0)
								seq_ff <= ea_ff;
						`OP_JZERO:
							if (acc_ff == 24'h0)
								seq_ff <= ea_ff;
						`OP_RESTORE:
						begin
							ovf_ff <= opnd_ff[`SB_OVF];
							carry_ff <= opnd_ff[`SB_CARRY];
							eovf_ff <= opnd_ff[`SB_EOVF];
							eunf_ff <= opnd_ff[`SB_EUNF];
							divo_ff <= opnd_ff[`SB_DIVO];
							blk_pend_ff <= opnd_ff[`SB_BLOCK];
						end
						`OP_NOADDR:
						begin
							case (iv)
								`NV_SHIFT:
								begin
									shcnt_ff <= ix[5:0];
									state_ff <= S_SHIFT;
								end
								`NV_XFER:
									if (t_ok)
									begin
										if (t_dst == 3'h0)
											acc_ff <= t_val;
										if (t_dst == 3'h1)
											breg_ff <= t_val;
										if (t_c[0] && t_src == 3'h0)
											acc_ff <= rsel(t_dst);
										if (t_c[0] && t_src == 3'h1)
											breg_ff <= rsel(t_dst);
									end
								`NV_ISKIP:
								begin
									if (tsel == 15'h0)
										seq_ff <= seq_ff + 15'h1;
									// sticky points except eovf_ff clear when looked at
									if (ix[`SB_OVF])
										ovf_ff <= 1'b0;
									if (ix[`SB_EUNF])
										eunf_ff <= 1'b0;
									if (ix[`SB_DIVO])
										divo_ff <= 1'b0;
									if (ix[`SB_EMERG] && !emg_s)
										emerg_ff <= 1'b0;
								end
								`NV_CSKIP:
								begin
									io_dev_addr_ff <= ix[8:0];
									io_ctrl_ff <= ix[14:9];
									io_req_ff <= 1'b1;
									ack_seen_ff <= 1'b0;
								end
								`NV_SETEXT:
									ext_point_ff <= ix;
								`NV_ESKIP:
									if ((ext_s & ix) == 15'h0)
										seq_ff <= seq_ff + 15'h1;
								`NV_HALT:
									if (ic == 3'h0)
									begin
										// only this sequencer stops
										seq_ff <= seq_ff - 15'h1;
										halted_ff <= 1'b1;
										state_ff <= S_HALT;
									end
								default:
									state_ff <= S_WAIT;
							endcase
						end
						default:
							state_ff <= S_WAIT;
					endcase
				end
				S_SHIFT:
				begin
					// one bit per cycle: small logic, slower long shifts
					if (shcnt_ff == 6'h0)
						state_ff <= S_WAIT;
					else
					begin
						shcnt_ff <= shcnt_ff - 6'h1;
						case (ix[14:12])
							3'h0: acc_ff <= {acc_ff[22:0], acc_ff[23]};
							3'h1: acc_ff <= {acc_ff[22:0], 1'b0};
							3'h2: acc_ff <= {acc_ff[0], acc_ff[23:1]};
							3'h3: acc_ff <= {acc_ff[23], acc_ff[23:1]};
							3'h4: {acc_ff, breg_ff} <= {acc_ff[22:0], breg_ff, acc_ff[23]};
							3'h5: {acc_ff, breg_ff} <= {acc_ff[22:0], breg_ff, 1'b0};
							3'h6: {acc_ff, breg_ff} <= {breg_ff[0], acc_ff, breg_ff[23:1]};
							default: {acc_ff, breg_ff} <= {acc_ff[23], acc_ff, breg_ff[23:1]};
						endcase
					end
				end
				S_WAIT:
					if (elapsed_ff + 16'h1 >= target)
					begin
						state_ff <= S_FETCH;
						if (io_req_ff)
						begin
							io_req_ff <= 1'b0;
							if (!ack_seen_ff && !ack_s)
								seq_ff <= seq_ff + 15'h1;
						end
					end
				S_HALT:
				begin
					if (reg_wr && reg_addr == `RA_SEQ)
						seq_ff <= reg_wdata[14:0];
					if (irq_s && !blk_ff)
					begin
						halted_ff <= 1'b0;
						state_ff <= S_FETCH;
					end
					else if (cont)
					begin
						halted_ff <= 1'b0;
						seq_ff <= seq_ff + 15'h1;
						state_ff <= S_FETCH;
					end
				end
				default:
					state_ff <= S_FETCH;
			endcase
			if (emg_s)
				emerg_ff <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// File: bench/aciu_chk_monitor.sv
/* port checker for the accumulator cpu instruction unit core.
   assumes one clk domain and rst_n asynchronous, active low. */
`default_nettype none
module aciu_chk (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// strobes
	input wire logic        mem_rd_ff,
	input wire logic        mem_wr_ff,
	input wire logic        reg_wr,
	// io bus, points, wake
	input wire logic [8:0]  io_dev_addr_ff,
	input wire logic [5:0]  io_ctrl_ff,
	input wire logic        io_req_ff,
	input wire logic [14:0] ext_point_ff,
	input wire logic        irq_in,
	input wire logic        halted_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] quiet_ff;
	// halted with no wake source; 4 cycles cover the 2-flop sync lag
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			quiet_ff <= 3'h0;
		else if (!halted_ff || irq_in || reg_wr)
			quiet_ff <= 3'h0;
		else if (quiet_ff != 3'h7)
			quiet_ff <= quiet_ff + 3'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_io_open;
		$rose(io_req_ff);
	endsequence
	sequence s_io_held;
		io_req_ff [*8];
	endsequence
	property p_mem_one;
		!(mem_rd_ff && mem_wr_ff);
	endproperty
	property p_halt_idle;
		quiet_ff >= 3'h4 |-> !mem_rd_ff && !mem_wr_ff;
	endproperty
	property p_halt_no_io;
		halted_ff |-> !io_req_ff;
	endproperty
	property p_io_min;
		s_io_open |-> s_io_held;
	endproperty
	property p_io_max;
		s_io_open |-> ##[1:1000] !io_req_ff;
	endproperty
	property p_io_hold;
		io_req_ff && $past(io_req_ff) |-> $stable(io_dev_addr_ff) && $stable(io_ctrl_ff);
	endproperty
	property p_io_no_wr;
		io_req_ff |-> !mem_wr_ff;
	endproperty
	property p_point_hold;
		$changed(ext_point_ff) |-> !halted_ff && !io_req_ff;
	endproperty
	a_mem_one: assert property (p_mem_one)
		else $error("memory read and write strobes together");
	a_halt_idle: assert property (p_halt_idle)
		else $error("memory access while halted");
	a_halt_no_io: assert property (p_halt_no_io)
		else $error("io request while halted");
	a_io_min: assert property (p_io_min)
		else $error("io request too short");
	a_io_max: assert property (p_io_max)
		else $error("io request too long");
	a_io_hold: assert property (p_io_hold)
		else $error("io address or control moved during request");
	a_io_no_wr: assert property (p_io_no_wr)
		else $error("memory write during io request");
	a_point_hold: assert property (p_point_hold)
		else $error("external points moved outside an order");
endmodule

bind aciu_core aciu_chk u_chk (
	.clk            (clk),
	.rst_n          (rst_n),
	.mem_rd_ff      (mem_rd_ff),
	.mem_wr_ff      (mem_wr_ff),
	.reg_wr         (reg_wr),
	.io_dev_addr_ff (io_dev_addr_ff),
	.io_ctrl_ff     (io_ctrl_ff),
	.io_req_ff      (io_req_ff),
	.ext_point_ff   (ext_point_ff),
	.irq_in         (irq_in),
	.halted_ff      (halted_ff)
);
`default_nettype wire

// File: bench/aciu_mem_model.sv
/* word memory and one io bus device facing the instruction unit.
   assumes registered strobes; read data answer within the strobe cycle. */
`default_nettype none
module aciu_mem_model (
	// clock
	input wire logic        clk,
	// word memory
	input wire logic [14:0] mem_addr_ff,
	input wire logic        mem_rd_ff,
	input wire logic        mem_wr_ff,
	input wire logic [23:0] mem_wdata_ff,
	output logic     [23:0] mem_rdata,
	// io device
	input wire logic        io_req_ff,
	input wire logic [8:0]  io_dev_addr_ff,
	input wire logic [8:0]  ack_dev,
	input wire logic [9:0]  ack_dly,
	output logic            io_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] mem [0:4095];
	logic [23:0] rd_ff = 24'h0;
	logic [9:0]  wait_ff = 10'h0;
	initial io_ack = 1'b0;
	always @(posedge clk)
	begin
		if (mem_rd_ff)
			rd_ff <= mem[mem_addr_ff[11:0]];
		if (mem_wr_ff)
			mem[mem_addr_ff[11:0]] <= mem_wdata_ff;
		wait_ff <= io_req_ff ? wait_ff + {9'h0, wait_ff != 10'h3ff} : 10'h0;
		// only the addressed device answers, after its own delay
		io_ack <= io_req_ff && io_dev_addr_ff == ack_dev && wait_ff >= ack_dly;
	end
	// unit latches data at the edge closing the strobe cycle; else inverse
	assign mem_rdata = mem_rd_ff ? mem[mem_addr_ff[11:0]] : ~rd_ff;
endmodule
`default_nettype wire

// File: bench/aciu_tb_top.sv
/* self-checking bench for the instruction unit core: runs a program
   from the memory model, checks at halts through the register port.
   assumes the core's header constants and a 250 mhz clock. */
`include "aciu_regs.vh"
`default_nettype none
module aciu_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, ce, reg_wr, reg_rd, irq_in, emerg_in, io_ack, io_req_ff;
	logic        mem_rd_ff, mem_wr_ff, halted_ff, cy, ov;
	logic [3:0]  reg_addr;
	logic [23:0] reg_wdata, reg_rdata_ff, mem_rdata, mem_wdata_ff, rv, a, b, c, d, s, sh;
	logic [14:0] mem_addr_ff, ext_point_ff, ext_point_in, sel, pt, st;
	logic [8:0]  io_dev_addr_ff, dev, ack_dev;
	logic [9:0]  ack_dly;
	logic [5:0]  io_ctrl_ff, ctl, sw, n, r;
	int          fails, compares, seed;
	localparam logic [23:0] stop_w = {`OP_NOADDR, `NV_HALT, 15'h0};

	aciu_core u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .mem_addr_ff(mem_addr_ff),
		.mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff), .mem_wdata_ff(mem_wdata_ff),
		.mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .io_dev_addr_ff(io_dev_addr_ff),
		.io_ctrl_ff(io_ctrl_ff), .io_req_ff(io_req_ff), .io_ack(io_ack),
		.io_wc_addr(st), .ext_point_ff(ext_point_ff), .ext_point_in(ext_point_in),
		.irq_in(irq_in), .emerg_in(emerg_in), .halted_ff(halted_ff));
	aciu_mem_model u_mem (.clk(clk), .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff),
		.mem_wr_ff(mem_wr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_rdata(mem_rdata),
		.io_req_ff(io_req_ff), .io_dev_addr_ff(io_dev_addr_ff), .ack_dev(ack_dev),
		.ack_dly(ack_dly), .io_ack(io_ack));

	function automatic logic [23:0] w(input logic [5:0] op, input logic [2:0] v,
		input logic [14:0] x);
		return {op, v, x};
	endfunction
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [3:0] ad);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata_ff;
	endtask
	task automatic wr(input logic [3:0] ad, input logic [23:0] dv);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dv;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic wait_halt(input logic [14:0] ex);
		repeat (8000) if (halted_ff !== 1'b1) @(posedge clk);
		chk({23'h0, halted_ff}, 24'h1);
		rd(`RA_SEQ);
		chk(rv, {9'h0, ex});
	endtask
	task automatic cont;
		wr(`RA_CTRL, 24'h1);
		repeat (20) if (halted_ff === 1'b1) @(posedge clk);
	endtask
	// a skip or taken jump lands on the second of two halts
	task automatic cond(input logic skip, input logic [14:0] base);
		wait_halt(skip ? base + 15'h1 : base);
		if (!skip)
		begin
			cont();
			wait_halt(base + 15'h1);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		end_of_test();
	end
	initial
	begin
		{rst_n, reg_wr, reg_rd, irq_in, emerg_in, reg_addr, reg_wdata} = '0;
		{ext_point_in, ack_dev, ack_dly, fails, compares} = '0;
		ce = 1'b1;
		seed = 45;
		a = $random(seed);
		b = $random(seed);
		c = 24'hffffff;
		d = $random(seed);
		{st, sel} = $random(seed);
		{dev, ctl, sw, r} = $random(seed);
		pt = st & ~sel;
		n = 6'd1 + 6'({$random(seed)} % 23);
		{cy, s} = {1'b0, a} + {1'b0, b};
		ov = a[23] == b[23] && s[23] != a[23];
		sh = $signed(s) >>> n;
		for (int i = 0; i < 4096; i++)
			u_mem.mem[i] = stop_w;
		u_mem.mem[12'h000] = w(`OP_ADD, 3'h0, 15'h100);
		u_mem.mem[12'h001] = w(`OP_ADD, 3'h0, 15'h101);
		u_mem.mem[12'h002] = w(`OP_ADDMEM, 3'h0, 15'h102);
		u_mem.mem[12'h003] = w(`OP_JNEG, 3'h0, 15'h005);
		u_mem.mem[12'h006] = w(`OP_BAR, 3'h0, 15'h110);
		u_mem.mem[12'h111] = w(`OP_NOADDR, `NV_SHIFT, 15'h3000 | {9'h0, n});
		u_mem.mem[12'h112] = w(`OP_NOADDR, `NV_XFER, 15'h0400);
		u_mem.mem[12'h114] = w(`OP_AUGIMM, 3'h1, 15'h0003);
		u_mem.mem[12'h115] = w(`OP_DECJMP, 3'h1, 15'h0115);
		u_mem.mem[12'h116] = w(`OP_NOADDR, `NV_XFER, 15'h0010);
		u_mem.mem[12'h117] = w(`OP_NOADDR, `NV_ISKIP, 15'h10c0);
		u_mem.mem[12'h119] = w(`OP_NOADDR, `NV_ISKIP, 15'h1000);
		u_mem.mem[12'h11c] = w(`OP_NOADDR, `NV_SETEXT, st);
		u_mem.mem[12'h11d] = w(`OP_NOADDR, `NV_ESKIP, sel | 15'h1);
		u_mem.mem[12'h120] = w(`OP_NOADDR, `NV_CSKIP, {ctl, dev});
		u_mem.mem[12'h123] = w(`OP_NOADDR, `NV_CSKIP, {~ctl, dev ^ 9'h1});
		u_mem.mem[12'h126] = w(`OP_REMOTE, 3'h0, 15'h0130);
		u_mem.mem[12'h130] = w(`OP_ADD, 3'h0, 15'h0131);
		u_mem.mem[12'h022] = w(`OP_RESTORE, 3'h0, 15'h0132);
		u_mem.mem[12'h023] = w(`OP_NOADDR, `NV_XFER, 15'h2000);
		u_mem.mem[12'h100] = a;
		u_mem.mem[12'h101] = b;
		u_mem.mem[12'h102] = c;
		u_mem.mem[12'h131] = d;
		u_mem.mem[12'h132] = {12'h0, r, 6'h0};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		emerg_in <= 1'b1;
		ext_point_in <= pt & ~(sel | 15'h1);
		ack_dev <= dev;
		ack_dly <= 10'd400;
		wr(`RA_SWITCH, {18'h0, sw});
		rd(`RA_SWITCH);
		chk(rv, {18'h0, sw});
		rd(4'hf);
		emerg_in <= 1'b0;
		chk(rv, 24'h0);
		cond(s[23], 15'h004);
		rd(`RA_ACC);
		chk(rv, s);
		rd(`RA_FLAGS);
		chk(rv & 24'h3fc0, {10'h0, 1'b1, 1'b1, 4'h0, cy, ov, 6'h0});
		chk(u_mem.mem[12'h102], s + c);
		cont();
		wait_halt(15'h113);
		rd(`RA_ACC);
		chk(rv, -sh);
		chk(u_mem.mem[12'h110], 24'h000007);
		cont();
		wait_halt(15'h118);
		rd(`RA_ACC);
		chk(rv, 24'h0);
		rd(`RA_FLAGS);
		chk(rv & 24'h1040, 24'h0);
		cont();
		wait_halt(15'h11b);
		cont();
		cond(1'b1, 15'h11e);
		chk({9'h0, ext_point_ff}, {9'h0, st});
		cont();
		cond(1'b0, 15'h121);
		cont();
		cond(1'b1, 15'h124);
		chk({9'h0, ~io_ctrl_ff, io_dev_addr_ff}, {9'h0, ctl, dev ^ 9'h1});
		cont();
		wait_halt(15'h127);
		rd(`RA_ACC);
		chk(rv, d);
		irq_in <= 1'b1;
		repeat (2000) if (u_mem.mem[12'h020] === stop_w) @(posedge clk);
		repeat (1000) if (halted_ff === 1'b1) @(posedge clk);
		wait_halt(15'h021);
		chk(u_mem.mem[12'h020], 24'h000127);
		irq_in <= 1'b0;
		cont();
		wait_halt(15'h024);
		rd(`RA_ACC);
		chk(rv, {9'h0, st});
		rd(`RA_FLAGS);
		chk(rv & 24'h0fc0, {12'h0, r, 6'h0});
		end_of_test();
	end
endmodule
`default_nettype wire
